// >>> verilog/csp_top.sv
// Two-wire and four-wire serial register port of the crosspoint switch.
`timescale 1ns/100ps

// Summary of operation
// - Termination control splits into four quadrants: outputs high/low, inputs high/low.
// - A set quadrant bit disables its terminations; all enabled after reset.
// - Reset pin low returns every register to default; held high in operation.
// - Writing 0x01 to write-only address 0x00 resets the register set.
// - Device is two-wire slave only and never drives the serial clock.
// - Two-wire slave works at 100 kHz and 400 kHz clock rates.
// - Data changes only while clock low, except start, repeated start, stop.
// - Data falling with clock high starts; data rising with clock high stops.
// - Seven-bit address, MSB first: fixed 10010 plus two select pins.
// - Write: address+0, register address, data byte; each acknowledged and stored.
// - Read: set address by write, repeated start, address+1 acknowledged.
// - After read address acknowledge, shift out the selected register's eight bits.
// - Stored register address persists until reset or a new address phase.
// - After a byte: stop, or repeated start for write, read, same-address read.
// - Four-wire port: chip select frames transfers; units are address or data bytes.
// - Each of sixteen outputs has a 16-bit advanced drive register pair.
// - Four-wire: input sampled on rising clock, output changes on falling clock.
// - Four-wire read: select rises after address byte; next frame streams data.
// - Four-wire pointer increments after each data byte for continuous access.
module csp_top (
	// System clock and reset pin.
	input wire logic sys_clk,
	input wire logic rst_n,
	// Two-wire port, clock is input only.
	input wire csp_pkg::csp_i2c_in_s i2c_in,
	output csp_pkg::csp_i2c_out_s i2c_out,
	input wire logic slave_addr_select_hi,
	input wire logic slave_addr_select_lo,
	// Four-wire port.
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	// Configuration towards the switch core.
	output csp_pkg::csp_cfg_s cfg
);

	typedef struct packed {
		logic scl_m, scl_s, scl_d;
		logic sda_m, sda_s, sda_d;
		logic cs_m, cs_s, cs_d;
		logic tg_m, tg_s, tg_d;
		logic [1:0] sel_m, sel_s;
		csp_pkg::csp_i2c_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		logic rw;
		logic mnak;
		logic sda_oe;
		logic [7:0] i_ptr;
		logic [7:0] s_ptr;
		logic [1:0] s_cnt;
		logic s_rd;
		logic [7:0] rd_byte;
		csp_pkg::csp_cfg_s cfg;
	} csp_state_s;

	csp_state_s r;
	csp_state_s next_r;

	////////////////////////////////////////////////////////////////////////////////
	// Register file access shared by both serial ports.

	function automatic csp_pkg::csp_cfg_s cfg_default();
		csp_pkg::csp_cfg_s c;
		c.term_dis = csp_pkg::TERM_RST;
		c.drive = {csp_pkg::N_OUT{csp_pkg::DRV_RST}};
		return c;
	endfunction : cfg_default

	function automatic logic [7:0] read_byte(input csp_pkg::csp_cfg_s c, input logic [7:0] a);
		logic [7:0] off;
		off = a - csp_pkg::REG_DRV_FIRST;
		if (a >= csp_pkg::REG_DRV_FIRST && a <= csp_pkg::REG_DRV_LAST) begin
			return c.drive[off[4:1]][{off[0], 3'h0} +: 8];
		end
		if (a == csp_pkg::REG_TERM) begin
			return {4'h0, c.term_dis};
		end
		// The reset register is write-only and unmapped space reads as zero.
		return 8'h00;
	endfunction : read_byte

	function automatic csp_pkg::csp_cfg_s write_byte(input csp_pkg::csp_cfg_s c,
			input logic [7:0] a, input logic [7:0] d);
		csp_pkg::csp_cfg_s o;
		logic [7:0] off;
		o = c;
		off = a - csp_pkg::REG_DRV_FIRST;
		if (a == csp_pkg::REG_SRST && d == csp_pkg::SRST_CODE) begin
			o = cfg_default();
		end else if (a >= csp_pkg::REG_DRV_FIRST && a <= csp_pkg::REG_DRV_LAST) begin
			o.drive[off[4:1]][{off[0], 3'h0} +: 8] = d;
		end else if (a == csp_pkg::REG_TERM) begin
			o.term_dis = d[3:0];
		end
		return o;
	endfunction : write_byte

	////////////////////////////////////////////////////////////////////////////////
	// Link domain of the four-wire port, clocked by its own serial clock.

	logic [2:0] l_bit;
	logic [6:0] l_shin;
	logic [7:0] l_rx;
	logic l_tg;
	logic l_started;
	logic [7:0] l_out;
	logic l_sdo;
	logic [7:0] l_src;

	// Chip select high clears the frame state, so every frame starts at bit zero.
	always_ff @(posedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			l_bit <= 3'h0;
			l_shin <= 7'h00;
		end else begin
			l_bit <= l_bit + 3'h1;
			l_shin <= {l_shin[5:0], spi_sdi};
		end
	end

	// The byte and its toggle survive chip select so the system side can still take it.
	always_ff @(posedge spi_sck or negedge rst_n) begin
		if (!rst_n) begin
			l_rx <= 8'h00;
			l_tg <= 1'b0;
		end else if (l_bit == 3'h7) begin
			l_rx <= {l_shin, spi_sdi};
			l_tg <= ~l_tg;
		end
	end

	// The prefetched byte is quasi-static: it changes only a few system clocks after a
	// byte completes, which limits the serial clock half period to above 120 ns.
	assign l_src = (l_bit == 3'h0 || !l_started) ? r.rd_byte : l_out;

	always_ff @(negedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n) begin
			l_started <= 1'b0;
			l_out <= 8'h00;
			l_sdo <= 1'b0;
		end else begin
			l_started <= 1'b1;
			l_out <= l_src;
			l_sdo <= l_src[~l_bit];
		end
	end

	// The first bit must stand before any falling edge of the frame.
	assign spi_sdo = l_started ? l_sdo : r.rd_byte[7];
	assign spi_sdo_oe = ~spi_cs_n;

	////////////////////////////////////////////////////////////////////////////////
	// System domain: line conditioning, two-wire slave and four-wire byte handling.

	logic scl_rise, scl_fall, cond_start, cond_stop, byte_done, spi_byte, i2c_wr;
	logic [6:0] own_addr;
	logic [7:0] rd_i2c;

	// Oversampling at the system clock keeps both two-wire rates well resolved.
	assign scl_rise = r.scl_s & ~r.scl_d;
	assign scl_fall = ~r.scl_s & r.scl_d;
	assign cond_start = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
	assign cond_stop = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
	assign byte_done = scl_fall && r.cnt == csp_pkg::BYTE_BITS;
	assign own_addr = {csp_pkg::DEV_ADDR_HI, r.sel_s};
	assign spi_byte = r.tg_s ^ r.tg_d;
	assign i2c_wr = r.st == csp_pkg::ST_WDAT && byte_done && !cond_start && !cond_stop;
	assign rd_i2c = read_byte(r.cfg, r.i_ptr);

	always_comb begin
		next_r = r;
		next_r.scl_m = i2c_in.scl;
		next_r.scl_s = r.scl_m;
		next_r.scl_d = r.scl_s;
		next_r.sda_m = i2c_in.sda;
		next_r.sda_s = r.sda_m;
		next_r.sda_d = r.sda_s;
		next_r.cs_m = spi_cs_n;
		next_r.cs_s = r.cs_m;
		next_r.cs_d = r.cs_s;
		next_r.tg_m = l_tg;
		next_r.tg_s = r.tg_m;
		next_r.tg_d = r.tg_s;
		next_r.sel_m = {slave_addr_select_hi, slave_addr_select_lo};
		next_r.sel_s = r.sel_m;

		if (cond_start) begin
			next_r.st = csp_pkg::ST_ADDR;
			next_r.cnt = 4'h0;
			next_r.sda_oe = 1'b0;
		end else if (cond_stop) begin
			next_r.st = csp_pkg::ST_IDLE;
			next_r.sda_oe = 1'b0;
		end else begin
			unique case (r.st)
				csp_pkg::ST_IDLE: begin
				end
				csp_pkg::ST_ADDR, csp_pkg::ST_REG, csp_pkg::ST_WDAT: begin
					if (scl_rise && r.cnt < csp_pkg::BYTE_BITS) begin
						next_r.sh = {r.sh[6:0], r.sda_s};
						next_r.cnt = r.cnt + 4'h1;
					end
					if (byte_done) begin
						next_r.cnt = 4'h0;
						next_r.sda_oe = 1'b1;
						if (r.st == csp_pkg::ST_ADDR) begin
							next_r.rw = r.sh[0];
							next_r.st = csp_pkg::ST_AACK;
							if (r.sh[7:1] != own_addr) begin
								next_r.sda_oe = 1'b0;
								next_r.st = csp_pkg::ST_IDLE;
							end
						end else if (r.st == csp_pkg::ST_REG) begin
							next_r.i_ptr = r.sh;
							next_r.st = csp_pkg::ST_RACK;
						end else begin
							next_r.cfg = write_byte(r.cfg, r.i_ptr, r.sh);
							next_r.st = csp_pkg::ST_DACK;
						end
					end
				end
				csp_pkg::ST_AACK: begin
					if (scl_fall) begin
						if (r.rw) begin
							next_r.sda_oe = ~rd_i2c[7];
							next_r.tx = {rd_i2c[6:0], 1'b0};
							next_r.cnt = 4'h1;
							next_r.st = csp_pkg::ST_RDAT;
						end else begin
							next_r.sda_oe = 1'b0;
							next_r.st = csp_pkg::ST_REG;
						end
					end
				end
				csp_pkg::ST_RACK, csp_pkg::ST_DACK: begin
					// Further bytes of one write land on the same register.
					if (scl_fall) begin
						next_r.sda_oe = 1'b0;
						next_r.st = csp_pkg::ST_WDAT;
					end
				end
				csp_pkg::ST_RDAT: begin
					if (scl_fall) begin
						if (r.cnt == csp_pkg::BYTE_BITS) begin
							next_r.sda_oe = 1'b0;
							next_r.st = csp_pkg::ST_MACK;
						end else begin
							next_r.sda_oe = ~r.tx[7];
							next_r.tx = {r.tx[6:0], 1'b0};
							next_r.cnt = r.cnt + 4'h1;
						end
					end
				end
				csp_pkg::ST_MACK: begin
					if (scl_rise) begin
						next_r.mnak = r.sda_s;
					end
					// The pointer does not advance, so a repeat read returns the same register.
					if (scl_fall) begin
						if (r.mnak) begin
							next_r.st = csp_pkg::ST_IDLE;
						end else begin
							next_r.sda_oe = ~rd_i2c[7];
							next_r.tx = {rd_i2c[6:0], 1'b0};
							next_r.cnt = 4'h1;
							next_r.st = csp_pkg::ST_RDAT;
						end
					end
				end
			endcase
		end

		// Four-wire bytes: in a write frame the first is the pointer, the rest data.
		if (spi_byte) begin
			if (r.s_rd) begin
				next_r.s_ptr = r.s_ptr + 8'h01;
			end else if (r.s_cnt == 2'h0) begin
				next_r.s_ptr = l_rx;
			end else begin
				next_r.cfg = write_byte(next_r.cfg, r.s_ptr, l_rx);
				next_r.s_ptr = r.s_ptr + 8'h01;
			end
			if (r.s_cnt != 2'h2) begin
				next_r.s_cnt = r.s_cnt + 2'h1;
			end
		end
		if (r.cs_s && !r.cs_d) begin
			// A pointer-only frame makes the next a read; a byte landing with this edge counts.
			next_r.s_rd = next_r.s_cnt == 2'h1 && !r.s_rd;
			next_r.s_cnt = 2'h0;
		end
		next_r.rd_byte = read_byte(next_r.cfg, next_r.s_ptr);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
			r.scl_m <= 1'b1;
			r.scl_s <= 1'b1;
			r.scl_d <= 1'b1;
			r.sda_m <= 1'b1;
			r.sda_s <= 1'b1;
			r.sda_d <= 1'b1;
			r.cs_m <= 1'b1;
			r.cs_s <= 1'b1;
			r.cs_d <= 1'b1;
			r.st <= csp_pkg::ST_IDLE;
			r.cfg <= cfg_default();
		end else begin
			r <= next_r;
		end
	end

	// Clock line is never an output, data line is open drain low only.
	assign i2c_out.sda_o = 1'b0;
	assign i2c_out.sda_oe = r.sda_oe;
	assign cfg = r.cfg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	a_own_addr_ack: assert property ((r.st == csp_pkg::ST_ADDR && byte_done && !cond_start &&
			!cond_stop && r.sh[7:1] == own_addr) |=> (r.sda_oe && r.st == csp_pkg::ST_AACK))
		else $error("own address not acknowledged");
	a_foreign_addr_quiet: assert property ((r.st == csp_pkg::ST_ADDR && byte_done &&
			!cond_start && !cond_stop && r.sh[7:1] != own_addr) |=> ((!r.sda_oe)[*2]))
		else $error("foreign address acknowledged");
	a_start_to_addr: assert property (cond_start |=> (r.st == csp_pkg::ST_ADDR && r.cnt == 4'h0))
		else $error("start not taken");
	a_stop_release: assert property (cond_stop |=> (r.st == csp_pkg::ST_IDLE && !r.sda_oe))
		else $error("stop did not release the bus");
	a_ptr_hold: assert property (!(r.st == csp_pkg::ST_REG && byte_done) |=> $stable(r.i_ptr))
		else $error("register address changed without address phase");
	a_soft_reset: assert property ((i2c_wr && !spi_byte && r.i_ptr == csp_pkg::REG_SRST &&
			r.sh == csp_pkg::SRST_CODE) |=> (r.cfg == cfg_default()))
		else $error("software reset missed");
	a_term_write: assert property ((i2c_wr && !spi_byte && r.i_ptr == csp_pkg::REG_TERM)
			|=> (r.cfg.term_dis == $past(r.sh[3:0])))
		else $error("termination write lost");
	a_read_first_bit: assert property ((r.st == csp_pkg::ST_AACK && scl_fall && r.rw &&
			!cond_start && !cond_stop) |=> (r.sda_oe == !$past(rd_i2c[7]) && r.st == csp_pkg::ST_RDAT))
		else $error("read data not driven");
	a_spi_increment: assert property ((spi_byte && (r.s_rd || r.s_cnt != 2'h0))
			|=> (r.s_ptr == $past(r.s_ptr) + 8'h01))
		else $error("pointer did not advance");

	c_i2c_write: cover property (i2c_wr);
	c_i2c_read_ack: cover property (r.st == csp_pkg::ST_MACK && scl_rise && !r.sda_s);
	c_spi_read: cover property (spi_byte && r.s_rd);
	c_soft_reset: cover property (i2c_wr && r.i_ptr == csp_pkg::REG_SRST);

endmodule : csp_top

// >>> verilog/csp_pkg.sv
// Shared constants, register map and carrier types of the crosspoint serial control port.
package csp_pkg;

	// Clock rates and the oversampling margin of the two-wire port.
	localparam int SYS_CLK_KHZ = 25000;
	localparam int SCL_STD_KHZ = 100;
	localparam int SCL_FAST_KHZ = 400;
	localparam int SCL_HALF_CYC = SYS_CLK_KHZ / (2 * SCL_FAST_KHZ);

	// Output count and width of one advanced drive register pair.
	localparam int N_OUT = 16;
	localparam int DRV_W = 16;

	// Fixed upper part of the seven-bit slave address.
	localparam logic [4:0] DEV_ADDR_HI = 5'h12;

	// Register offsets and the software reset code.
	localparam logic [7:0] REG_SRST = 8'h00;
	localparam logic [7:0] SRST_CODE = 8'h01;
	localparam logic [7:0] REG_DRV_FIRST = 8'h30;
	localparam logic [7:0] REG_DRV_LAST = 8'h4f;
	localparam logic [7:0] REG_TERM = 8'hf0;

	// Field positions of the termination control register.
	localparam int TERM_OUT_HI = 3;
	localparam int TERM_OUT_LO = 2;
	localparam int TERM_IN_HI = 1;
	localparam int TERM_IN_LO = 0;

	// Values after reset.
	localparam logic [3:0] TERM_RST = 4'h0;
	localparam logic [15:0] DRV_RST = 16'h0000;

	// Bits in one serial byte.
	localparam logic [3:0] BYTE_BITS = 4'h8;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_REG, ST_RACK, ST_WDAT, ST_DACK, ST_RDAT, ST_MACK
	} csp_i2c_e;

	typedef struct packed {
		logic [3:0] term_dis;
		logic [N_OUT-1:0][DRV_W-1:0] drive;
	} csp_cfg_s;

	typedef struct packed {
		logic scl;
		logic sda;
	} csp_i2c_in_s;

	typedef struct packed {
		logic sda_o;
		logic sda_oe;
	} csp_i2c_out_s;

endpackage : csp_pkg

// >>> tb/csp_i2c_master_model.sv
// Two-wire bus master model with the pull-up of the data line.
`timescale 1ns/100ps

module csp_i2c_master_model (
	// Pacing clock.
	input wire logic sys_clk,
	// Device side of the data line.
	input wire csp_pkg::csp_i2c_out_s dev_out,
	// Bus lines as the device sees them.
	output csp_pkg::csp_i2c_in_s bus
);
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;
	int half = csp_pkg::SCL_HALF_CYC;

	////////////////////////////////////////////////////////////////////////////////
	// The pull-up wins unless a party pulls low; the clock is ours alone.
	assign bus = {m_scl, m_sda & ~(dev_out.sda_oe & ~dev_out.sda_o)};

	task automatic wait_n(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : wait_n

	// Data goes high before the clock rises, so this also forms a repeated start.
	task automatic start();
		m_sda <= 1'b1;
		wait_n(half);
		m_scl <= 1'b1;
		wait_n(half);
		m_sda <= 1'b0;
		wait_n(half);
		m_scl <= 1'b0;
		wait_n(2);
	endtask : start

	task automatic stop();
		m_sda <= 1'b0;
		wait_n(half);
		m_scl <= 1'b1;
		wait_n(half);
		m_sda <= 1'b1;
		wait_n(half);
	endtask : stop

	// Data is moved two edges after the clock falls, never while it is high.
	task automatic clk_bit(input logic v, output logic s);
		m_sda <= v;
		wait_n(half);
		m_scl <= 1'b1;
		wait_n(half);
		s = bus.sda;
		m_scl <= 1'b0;
		wait_n(2);
	endtask : clk_bit

	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(b[i], s);
		end
		clk_bit(1'b1, s);
		ack = ~s;
	endtask : put_byte

	task automatic get_byte(input logic nak, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, d[i]);
		end
		clk_bit(nak, s);
	endtask : get_byte

endmodule : csp_i2c_master_model

// >>> tb/crosspoint_serial_control_port_tb.sv
// Self-checking testbench of the crosspoint serial control port.
`timescale 1ns/100ps

module crosspoint_serial_control_port_tb;
	localparam logic [6:0] DEV = {csp_pkg::DEV_ADDR_HI, 2'b01};
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic sel_hi = 1'b0;
	logic sel_lo = 1'b1;
	logic spi_sck = 1'b0;
	logic spi_cs_n = 1'b1;
	logic spi_sdi = 1'b0;
	logic spi_sdo;
	logic spi_sdo_oe;
	csp_pkg::csp_i2c_in_s i2c_in;
	csp_pkg::csp_i2c_out_s i2c_out;
	csp_pkg::csp_cfg_s cfg;
	int n_mismatch = 0;
	int n_tests = 0;
	int cycles = 0;
	logic ack;
	logic [23:0] rx;

	csp_top u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .i2c_in(i2c_in), .i2c_out(i2c_out),
		.slave_addr_select_hi(sel_hi), .slave_addr_select_lo(sel_lo),
		.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .cfg(cfg)
	);

	csp_i2c_master_model u_master (.sys_clk(sys_clk), .dev_out(i2c_out), .bus(i2c_in));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #20 sys_clk = ~sys_clk;
	end

	task close_out;
		$display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : close_out

	// The whole run needs about forty thousand cycles.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_mismatch = n_mismatch + 1;
			close_out();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk

	////////////////////////////////////////////////////////////////////////////////
	task automatic i2c_wr(input logic [7:0] ra, input logic [7:0] d);
		logic a;
		u_master.start();
		u_master.put_byte({DEV, 1'b0}, a);
		chk(16'(a), 16'h0001, "address ack");
		u_master.put_byte(ra, a);
		chk(16'(a), 16'h0001, "register ack");
		u_master.put_byte(d, a);
		chk(16'(a), 16'h0001, "data ack");
		u_master.stop();
	endtask : i2c_wr

	// Without the pointer phase the read uses the stored register address.
	task automatic i2c_rd(input logic setp, input logic [7:0] ra, input logic [7:0] exp);
		logic a;
		logic [7:0] d;
		if (setp) begin
			u_master.start();
			u_master.put_byte({DEV, 1'b0}, a);
			u_master.put_byte(ra, a);
			chk(16'(a), 16'h0001, "pointer ack");
		end
		u_master.start();
		u_master.put_byte({DEV, 1'b1}, a);
		chk(16'(a), 16'h0001, "read address ack");
		u_master.get_byte(1'b0, d);
		chk(16'(d), 16'(exp), "read data");
		u_master.get_byte(1'b1, d);
		chk(16'(d), 16'(exp), "read data again");
		u_master.stop();
	endtask : i2c_rd

	// The link clock runs only inside a frame.
	task automatic spi_frame(input int n, input int h, input logic [23:0] tx);
		@(posedge sys_clk);
		#7;
		spi_cs_n <= 1'b0;
		#(h);
		chk(16'(spi_sdo_oe), 16'h0001, "sdo enable");
		for (int i = 0; i < n * 8; i++) begin
			spi_sdi <= tx[23 - i];
			#(h);
			spi_sck <= 1'b1;
			rx[23 - i] = spi_sdo;
			#(h);
			spi_sck <= 1'b0;
		end
		#(h);
		spi_cs_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
	endtask : spi_frame

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		chk(16'(cfg.term_dis), 16'(csp_pkg::TERM_RST), "term after reset");
		chk(cfg.drive[5], csp_pkg::DRV_RST, "drive after reset");
		chk(16'(i2c_out.sda_oe), 16'h0000, "idle data line");
		chk(16'(i2c_out.sda_o), 16'h0000, "open drain level");
		$display("test reset values done");
		for (int q = 0; q < 4; q++) begin
			i2c_wr(csp_pkg::REG_TERM, 8'(1 << q));
			chk(16'(cfg.term_dis), 16'(1 << q), "quadrant bit");
		end
		i2c_rd(1'b1, csp_pkg::REG_TERM, 8'h08);
		i2c_wr(csp_pkg::REG_TERM, 8'h05);
		i2c_rd(1'b0, 8'h00, 8'h05);
		$display("test termination done");
		i2c_wr(8'h37, 8'hab);
		i2c_wr(8'h36, 8'hcd);
		chk(cfg.drive[3], 16'habcd, "drive pair");
		i2c_wr(csp_pkg::REG_DRV_LAST, 8'h5a);
		chk(cfg.drive[15], 16'h5a00, "last drive");
		u_master.start();
		u_master.put_byte({csp_pkg::DEV_ADDR_HI, 2'b10, 1'b0}, ack);
		chk(16'(ack), 16'h0000, "foreign address");
		u_master.stop();
		$display("test drive and address done");
		u_master.half = csp_pkg::SYS_CLK_KHZ / (2 * csp_pkg::SCL_STD_KHZ);
		i2c_wr(csp_pkg::REG_TERM, 8'h0f);
		chk(16'(cfg.term_dis), 16'h000f, "standard rate");
		u_master.half = csp_pkg::SCL_HALF_CYC;
		i2c_wr(csp_pkg::REG_SRST, 8'h02);
		chk(16'(cfg.term_dis), 16'h000f, "other code ignored");
		i2c_wr(csp_pkg::REG_SRST, csp_pkg::SRST_CODE);
		chk(16'(cfg.term_dis), 16'h0000, "soft reset term");
		chk(cfg.drive[3], csp_pkg::DRV_RST, "soft reset drive");
		i2c_rd(1'b1, csp_pkg::REG_SRST, 8'h00);
		$display("test rates and soft reset done");
		spi_frame(3, 200, {8'h30, 8'h11, 8'h22});
		chk(cfg.drive[0], 16'h2211, "spi burst write");
		spi_frame(1, 6, {8'h30, 16'h0000});
		spi_frame(2, 200, 24'h000000);
		chk(rx[23:8], 16'h1122, "spi stream");
		chk(16'(spi_sdo_oe), 16'h0000, "sdo released");
		$display("test four-wire done");
		i2c_wr(csp_pkg::REG_TERM, 8'h09);
		chk(16'(cfg.term_dis), 16'h0009, "term before pin reset");
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(16'(cfg.term_dis), 16'h0000, "pin reset term");
		chk(cfg.drive[0], csp_pkg::DRV_RST, "pin reset drive");
		rst_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		i2c_rd(1'b1, csp_pkg::REG_TERM, 8'h00);
		$display("test pin reset done");
		close_out();
	end

endmodule : crosspoint_serial_control_port_tb
